// file: pkg/dio_pkg.sv
// constants, enumerations and carrier types of the discrete i/o logic unit
package dio_pkg;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam int TC_MAX = 5000;
   localparam int HYS_MAX = 9999;
   // ************************************************
   // sizes
   // ************************************************
   localparam int N_DI = 10;
   localparam int N_DI_STD = 4;
   localparam int N_DO = 9;
   localparam int N_DO_STD = 5;
   localparam int N_EV = 3;
   localparam int N_TS = 16;
   localparam int N_SRC = N_TS + N_DI;
   localparam int N_LG = 8;
   // ************************************************
   // register byte offsets and reset values
   // ************************************************
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_FUNC_LO = 12'h004;
   localparam logic [11:0] OFS_FUNC_HI = 12'h008;
   localparam logic [11:0] OFS_CHSEL = 12'h00c;
   localparam logic [11:0] OFS_LOGIC0 = 12'h010;
   localparam logic [11:0] OFS_TC4 = 12'h030;
   localparam logic [11:0] OFS_TC5 = 12'h034;
   localparam logic [11:0] OFS_ROUTE = 12'h038;
   localparam logic [11:0] OFS_DIRECT = 12'h03c;
   localparam logic [11:0] OFS_ALARM = 12'h040;
   localparam logic [11:0] OFS_STATUS = 12'h044;
   localparam logic [11:0] OFS_DISTATE = 12'h048;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_ALARM = 32'h0001_0000;
   // ************************************************
   // types
   // ************************************************
   typedef enum logic [3:0] {
      FN_NONE = 4'h0, FN_RUN = 4'h1, FN_RST = 4'h2, FN_HOLD = 4'h3,
      FN_STEP = 4'h4, FN_FIX = 4'h5, FN_HAND = 4'h6, FN_LOGIC = 4'h7,
      FN_PTN2 = 4'h8, FN_PTN3 = 4'h9, FN_PTN4 = 4'ha, FN_PTN5 = 4'hb
   } di_func_t;
   typedef enum logic [1:0] {
      C_PASS = 2'b00, C_NEG = 2'b01, C_TOGGLE = 2'b10
   } cond_t;
   typedef enum logic [1:0] {
      OP_AND = 2'b00, OP_OR = 2'b01, OP_XOR = 2'b10
   } op_t;
   typedef enum logic [1:0] {
      AL_OFF = 2'b00, AL_HIGH = 2'b01, AL_LOW = 2'b10
   } alarm_type_t;
   typedef struct packed {
      logic [1:0] op;
      logic [1:0] c2;
      logic [1:0] c1;
      logic [4:0] s2;
      logic [4:0] s1;
   } logic_cfg_t;
   typedef struct packed {
      logic cnt_mode;
      logic [12:0] preset;
   } tc_cfg_t;
   typedef struct packed {
      logic run;
      logic hold;
      logic step;
      logic hand;
      logic fix;
   } ch_cmd_t;
endpackage

// file: src/discrete_io_logic_unit.sv
// contact input decoding, logic stage and switched outputs, apb registers
`timescale 1ns/10ps
// Function
// (RULE1) nine switched outputs, four need option
// (RULE2) outputs refresh once per 100 ms
// (RULE3) per-output polarity, closed or open asserted
// (RULE4) logic to outputs 1-5, direct 6-9
// (RULE5) ten contact inputs, six need option
// (RULE6) far side holds inputs 100 ms
// (RULE7) twelve input functions, channel one/two/both
// (RULE8) run switch: run while on, reset off
// (RULE9) forced reset holds reset while on
// (RULE10) hold suspends program while on
// (RULE11) advance steps program when asserted
// (RULE12) manual input selects hand operation
// (RULE13) 2-5 weighted bits pick 3/7/15/20 patterns
// (RULE14) logic results go to eight outputs
// (RULE15) operands: sixteen time signals or contacts
// (RULE16) sources pass, negate or toggle
// (RULE17) toggle refused on time signal source
// (RULE18) sources combined by and, or, xor
// (RULE19) outputs 4-5 only timer or counter
// (RULE20) timer off or 1 to 5000 s
// (RULE21) counter off or 1 to 5000 counts
// (RULE22) alarm hysteresis 1 to 9999 units
// (RULE23) alarm standby after power-up, reset-to-run
// (RULE24) toggle flips on rising source, resets clear; the latches clear only on presetn, not on forced reset
// (RULE25) timer after held time, counter after count
// (RULE26) sample and evaluate on 100 ms tick
module discrete_io_logic_unit #(
   parameter int TICK_CYCLES = dio_pkg::TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [dio_pkg::N_DI-1:0] contact_input,
   input wire logic option_fitted,
   input wire logic [dio_pkg::N_TS-1:0] time_signal_n,
   input wire logic signed [15:0] process_value,
   output logic [dio_pkg::N_DO-1:0] do_drive,
   output logic [dio_pkg::N_EV-1:0] event_output_n,
   output dio_pkg::ch_cmd_t channel_one,
   output dio_pkg::ch_cmd_t channel_two,
   output logic [4:0] start_pattern_select
);
   import dio_pkg::*;
   localparam int TW = $clog2(TICK_CYCLES);

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic sel_f(input logic [N_SRC-1:0] v,
                                  input logic [4:0] s);
      sel_f = (s < 5'(N_SRC)) ? v[s] : 1'b0;
   endfunction
   function automatic logic cond_f(input logic [1:0] c, input logic v,
                                   input logic t);
      case (c)
         C_NEG: cond_f = !v;
         C_TOGGLE: cond_f = t;
         default: cond_f = v;
      endcase
   endfunction
   function automatic logic op_f(input logic [1:0] o, input logic a,
                                 input logic b);
      case (o)
         OP_OR: op_f = a | b;
         OP_XOR: op_f = a ^ b;
         default: op_f = a & b;
      endcase
   endfunction
   // toggle on a time signal silently falls back to pass
   function automatic logic_cfg_t fix_cfg(input logic_cfg_t c);
      fix_cfg = c;
      if (c.c1 == C_TOGGLE && c.s1 < 5'(N_TS)) begin // RULE17
         fix_cfg.c1 = C_PASS;
      end
      if (c.c2 == C_TOGGLE && c.s2 < 5'(N_TS)) begin // RULE17
         fix_cfg.c2 = C_PASS;
      end
   endfunction
   function automatic tc_cfg_t fix_tc(input logic [31:0] d);
      fix_tc.cnt_mode = d[16];
      fix_tc.preset = (d[12:0] > 13'(TC_MAX)) ? 13'(TC_MAX) : d[12:0];
   endfunction
   function automatic logic [4:0] lim_f(input logic [2:0] w);
      case (w)
         3'd2: lim_f = 5'd3;
         3'd3: lim_f = 5'd7;
         3'd4: lim_f = 5'd15;
         3'd5: lim_f = 5'd20;
         default: lim_f = 5'd0;
      endcase
   endfunction

   // ************************************************
   // registers
   // ************************************************
   logic [31:0] ctrl_r, func_lo_r, alarm_r;
   logic [7:0] func_hi_r;
   logic [19:0] chsel_r;
   logic_cfg_t lg_cfg_r [N_LG];
   tc_cfg_t tc_cfg_r [2];
   logic [8:0] route_r;
   logic [3:0] direct_r;
   wire [8:0] pol = ctrl_r[8:0];
   wire dual = ctrl_r[9];
   wire stby_en = ctrl_r[10];
   wire [1:0] sw_run = ctrl_r[12:11];
   wire [39:0] fn_all = {func_hi_r, func_lo_r};

   // ************************************************
   // tick, synchronisers, sampling
   // ************************************************
   logic [TW-1:0] tick_cnt_r;
   logic tick_r;
   logic [N_DI-1:0] di_s1_r, di_s2_r, di_smp_r;
   logic opt_s1_r, opt_s2_r;
   logic [N_SRC-1:0] src_prev_r;
   wire [N_DI-1:0] di_mask = opt_s2_r ? {N_DI{1'b1}} : N_DI'(4'hf);
   wire [N_SRC-1:0] src_vec = {di_smp_r, time_signal_n};
   wire [N_SRC-1:0] src_rise = src_vec & ~src_prev_r;

   // free-running 100 ms pacing tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == TW'(TICK_CYCLES - 2)); // RULE26
         tick_cnt_r <= (tick_cnt_r == TW'(TICK_CYCLES - 1)) ?
                       '0 : tick_cnt_r + 1'b1;
      end
   end

   // contacts are sampled only on the tick, so a level shorter
   // than the tick period may be missed entirely
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         di_s1_r <= '0;
         di_s2_r <= '0;
         opt_s1_r <= 1'b0;
         opt_s2_r <= 1'b0;
         di_smp_r <= '0;
         src_prev_r <= '0;
      end else begin
         di_s1_r <= contact_input;
         di_s2_r <= di_s1_r;
         opt_s1_r <= option_fitted;
         opt_s2_r <= opt_s1_r;
         if (tick_r) begin
            di_smp_r <= di_s2_r & di_mask; // RULE5 RULE6 RULE26
            src_prev_r <= src_vec;
         end
      end
   end

   // ************************************************
   // contact input function decode
   // ************************************************
   logic [1:0] has_run, run_on, rst_on, hold_on, step_on, fix_on, hand_on;
   logic [3:0] fn;
   logic [1:0] chm;
   logic [4:0] pat_v;
   logic [2:0] pcnt, pw, w;
   ch_cmd_t cmd_nxt [2];
   wire [4:0] pat_lim = lim_f(pw);
   wire [4:0] pattern_nxt = (pat_v > pat_lim) ? pat_lim : pat_v;

   // each input acts on its channel(s); patterns take bits in input order
   always_comb begin
      has_run = '0;
      run_on = '0;
      rst_on = '0;
      hold_on = '0;
      step_on = '0;
      fix_on = '0;
      hand_on = '0;
      fn = '0;
      chm = '0;
      pat_v = '0;
      pcnt = '0;
      pw = '0;
      w = '0;
      for (int i = 0; i < N_DI; i++) begin
         fn = fn_all[4*i +: 4];
         chm = dual ? chsel_r[2*i +: 2] : 2'b01; // RULE7
         for (int c = 0; c < 2; c++) begin
            if (chm[c]) begin
               case (fn)
                  FN_RUN: begin
                     has_run[c] = 1'b1;
                     run_on[c] = run_on[c] | di_smp_r[i]; // RULE8
                  end
                  FN_RST: rst_on[c] = rst_on[c] | di_smp_r[i]; // RULE9
                  FN_HOLD: hold_on[c] = hold_on[c] | di_smp_r[i]; // RULE10
                  FN_STEP: step_on[c] = step_on[c] | src_rise[N_TS+i];
                  FN_FIX: fix_on[c] = fix_on[c] | di_smp_r[i];
                  FN_HAND: hand_on[c] = hand_on[c] | di_smp_r[i]; // RULE12
                  default: ;
               endcase
            end
         end
         if (fn >= FN_PTN2 && fn <= FN_PTN5) begin
            w = 3'(fn - FN_PTN2) + 3'd2; // RULE13
            if (w > pw) begin
               pw = w;
            end
            if (pcnt < w) begin
               pat_v[pcnt] = di_smp_r[i];
               pcnt = pcnt + 3'd1;
            end
         end
      end
      for (int c = 0; c < 2; c++) begin
         cmd_nxt[c].run = (has_run[c] ? run_on[c] : sw_run[c]) & ~rst_on[c];
         cmd_nxt[c].hold = hold_on[c];
         cmd_nxt[c].step = step_on[c]; // RULE11
         cmd_nxt[c].hand = hand_on[c];
         cmd_nxt[c].fix = fix_on[c];
      end
   end

   // ************************************************
   // logic stage: condition, combine, timer/counter
   // ************************************************
   logic [N_LG-1:0][1:0] tog_r, tog_nxt;
   logic [5:0] comb_res;
   logic [3:0] tc_sub_r [2];
   logic [12:0] tc_cnt_r [2];
   logic [1:0] tc_src, tc_out;

   // toggle latches flip on source rising edges only at the tick
   always_comb begin
      tog_nxt = tog_r;
      comb_res = '0;
      for (int k = 0; k < 6; k++) begin
         if (tick_r && lg_cfg_r[k].c1 == C_TOGGLE &&
             sel_f(src_rise, lg_cfg_r[k].s1)) begin
            tog_nxt[k][0] = !tog_r[k][0]; // RULE24
         end
         if (tick_r && lg_cfg_r[k].c2 == C_TOGGLE &&
             sel_f(src_rise, lg_cfg_r[k].s2)) begin
            tog_nxt[k][1] = !tog_r[k][1]; // RULE24
         end
         comb_res[k] = op_f(lg_cfg_r[k].op, // RULE18
            cond_f(lg_cfg_r[k].c1, sel_f(src_vec, lg_cfg_r[k].s1),
                   tog_r[k][0]), // RULE15 RULE16
            cond_f(lg_cfg_r[k].c2, sel_f(src_vec, lg_cfg_r[k].s2),
                   tog_r[k][1]));
      end
   end
   // outputs 4 and 5 come from source one through timer or counter
   for (genvar j = 0; j < 2; j++) begin : g_tc
      assign tc_src[j] = sel_f(src_vec, lg_cfg_r[N_EV+3+j].s1); // RULE19
      assign tc_out[j] = (tc_cfg_r[j].preset != '0) &&
                         (tc_cnt_r[j] >= tc_cfg_r[j].preset); // RULE25
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tc_sub_r[j] <= '0;
            tc_cnt_r[j] <= '0;
         end else if (tick_r) begin
            if (tc_cfg_r[j].cnt_mode) begin
               if (!channel_one.run && !sw_run[0] && rst_on[0]) begin
                  tc_cnt_r[j] <= '0;
               end else if (tc_src[j] && !sel_f(src_prev_r,
                            lg_cfg_r[N_EV+3+j].s1) &&
                            tc_cnt_r[j] < tc_cfg_r[j].preset) begin
                  tc_cnt_r[j] <= tc_cnt_r[j] + 13'd1; // RULE21 RULE25
               end
            end else if (!tc_src[j]) begin
               tc_sub_r[j] <= '0;
               tc_cnt_r[j] <= '0;
            end else if (tc_sub_r[j] == 4'(TICKS_PER_S - 1)) begin
               tc_sub_r[j] <= '0;
               if (tc_cnt_r[j] < tc_cfg_r[j].preset) begin
                  tc_cnt_r[j] <= tc_cnt_r[j] + 13'd1; // RULE20 RULE25
               end
            end else begin
               tc_sub_r[j] <= tc_sub_r[j] + 4'd1;
            end
         end
      end
   end

   // ************************************************
   // alarm with hysteresis and standby
   // ************************************************
   logic alm_raw_r, stby_r;
   wire signed [17:0] pv_e = 18'(process_value);
   wire signed [17:0] thr_e = 18'(signed'(alarm_r[15:0]));
   wire signed [17:0] hys_e = signed'({4'h0, alarm_r[29:16]});
   wire [1:0] al_type = alarm_r[31:30];
   wire alm_hi = alm_raw_r ? (pv_e >= thr_e - hys_e) : (pv_e >= thr_e);
   wire alm_lo = alm_raw_r ? (pv_e <= thr_e + hys_e) : (pv_e <= thr_e);
   wire alm_raw_nxt = (al_type == AL_HIGH) ? alm_hi : // RULE22
                      (al_type == AL_LOW) ? alm_lo : 1'b0;
   wire alm_out = alm_raw_r & ~(stby_en & stby_r); // RULE23

   // standby re-arms at reset-to-run, clears once condition is false
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alm_raw_r <= 1'b0;
         stby_r <= 1'b1;
      end else if (tick_r) begin
         alm_raw_r <= alm_raw_nxt;
         if (cmd_nxt[0].run && !channel_one.run) begin
            stby_r <= 1'b1; // RULE23
         end else if (!alm_raw_nxt) begin
            stby_r <= 1'b0;
         end
      end
   end

   // ************************************************
   // output stage, refreshed on the tick only, except the step pulses that clear the next cycle
   // ************************************************
   wire [8:0] do_state = {
      opt_s2_r ? (route_r[8:5] & direct_r | ~route_r[8:5] & {4{alm_out}})
               : 4'h0, // RULE1 RULE4
      route_r[4:3] & tc_out | ~route_r[4:3] & {2{alm_out}},
      route_r[2:0] & comb_res[5:3] | ~route_r[2:0] & {3{alm_out}}};
   wire [8:0] fit_mask = opt_s2_r ? 9'h1ff : 9'h01f;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         do_drive <= '0;
         event_output_n <= '0;
         channel_one <= '0;
         channel_two <= '0;
         start_pattern_select <= '0;
         tog_r <= '0;
      end else begin
         tog_r <= tog_nxt;
         channel_one.step <= tick_r & cmd_nxt[0].step;
         channel_two.step <= tick_r & cmd_nxt[1].step;
         if (tick_r) begin
            do_drive <= (do_state ^ pol) & fit_mask; // RULE2 RULE3
            event_output_n <= comb_res[2:0]; // RULE14
            {channel_one.run, channel_one.hold} <=
               {cmd_nxt[0].run, cmd_nxt[0].hold};
            {channel_one.hand, channel_one.fix} <=
               {cmd_nxt[0].hand, cmd_nxt[0].fix};
            {channel_two.run, channel_two.hold} <=
               {cmd_nxt[1].run, cmd_nxt[1].hold};
            {channel_two.hand, channel_two.fix} <=
               {cmd_nxt[1].hand, cmd_nxt[1].fix};
            start_pattern_select <= pattern_nxt;
         end
      end
   end

   // ************************************************
   // apb slave: zero wait state, data set up in the setup phase
   // ************************************************
   wire setup = psel & ~penable;
   wire [9:0] widx = paddr[11:2];
   wire aligned = paddr[1:0] == 2'b00;
   wire lg_hit = aligned && paddr >= OFS_LOGIC0 && paddr < OFS_TC4;
   wire [2:0] lg_idx = 3'(widx - OFS_LOGIC0[11:2]);
   wire wr = psel & penable & pready & pwrite & ~pslverr;
   logic [31:0] rd_mux;
   logic rd_err;

   // read selection; unmapped or unaligned answers with pslverr
   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      if (lg_hit) begin
         rd_mux = 32'(lg_cfg_r[lg_idx]);
      end else if (!aligned) begin
         rd_err = 1'b1;
      end else begin
         case (paddr)
            OFS_CTRL: rd_mux = ctrl_r;
            OFS_FUNC_LO: rd_mux = func_lo_r;
            OFS_FUNC_HI: rd_mux = 32'(func_hi_r);
            OFS_CHSEL: rd_mux = 32'(chsel_r);
            OFS_TC4: rd_mux = 32'(tc_cfg_r[0]);
            OFS_TC5: rd_mux = 32'(tc_cfg_r[1]);
            OFS_ROUTE: rd_mux = 32'(route_r);
            OFS_DIRECT: rd_mux = 32'(direct_r);
            OFS_ALARM: rd_mux = alarm_r;
            OFS_STATUS: rd_mux = {7'h00, opt_s2_r, start_pattern_select,
               alm_out, channel_two.hand, channel_one.hand,
               channel_two.hold, channel_one.hold, channel_two.run,
               channel_one.run, event_output_n, do_drive};
            OFS_DISTATE: rd_mux = 32'(di_smp_r);
            default: rd_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? rd_mux : '0;
         pslverr <= setup & rd_err;
      end
   end

   // register writes take effect at the completing access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= RST_ZERO;
         func_lo_r <= RST_ZERO;
         func_hi_r <= '0;
         chsel_r <= '0;
         lg_cfg_r <= '{default: '0};
         tc_cfg_r <= '{default: '0};
         route_r <= '0;
         direct_r <= '0;
         alarm_r <= RST_ALARM;
      end else if (wr) begin
         if (lg_hit) begin
            lg_cfg_r[lg_idx] <= fix_cfg(pwdata[15:0]); // RULE17
         end
         case (paddr)
            OFS_CTRL: ctrl_r <= {19'h0_0000, pwdata[12:0]};
            OFS_FUNC_LO: func_lo_r <= pwdata; // RULE7
            OFS_FUNC_HI: func_hi_r <= pwdata[7:0];
            OFS_CHSEL: chsel_r <= pwdata[19:0];
            OFS_TC4: tc_cfg_r[0] <= fix_tc(pwdata); // RULE20 RULE21
            OFS_TC5: tc_cfg_r[1] <= fix_tc(pwdata);
            OFS_ROUTE: route_r <= pwdata[8:0]; // RULE4
            OFS_DIRECT: direct_r <= pwdata[3:0];
            OFS_ALARM: alarm_r <= {pwdata[31:30],
               (pwdata[29:16] == 14'h0000) ? 14'h0001 :
               (pwdata[29:16] > 14'(HYS_MAX)) ? 14'(HYS_MAX) :
               pwdata[29:16], pwdata[15:0]}; // RULE22
            default: ;
         endcase
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   logic [TW-1:0] gap_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r <= '0;
      end else begin
         gap_r <= tick_r ? '0 : gap_r + 1'b1;
      end
   end
   sequence tick_s;
      tick_r;
   endsequence
   sequence reset_in_s;
      tick_r && rst_on[0];
   endsequence
   tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_r && gap_r != '0 |-> gap_r == TW'(TICK_CYCLES - 1)) // RULE26
      else $error("tick period wrong");
   do_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$stable(do_drive) |-> $past(tick_r)) // RULE2
      else $error("output changed off tick");
   unfitted_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_s ##0 !opt_s2_r |=> do_drive[8:5] == 4'h0) // RULE1
      else $error("option output driven");
   direct_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_s ##0 opt_s2_r && route_r[5] |=>
      do_drive[5] == ($past(direct_r[0]) ^ $past(pol[5]))) // RULE3
      else $error("direct output wrong");
   force_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
      reset_in_s |=> !channel_one.run ##1 !channel_one.run) // RULE9
      else $error("run during forced reset");
   run_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_s ##0 has_run[0] && run_on[0] && !rst_on[0] |=>
      channel_one.run) // RULE8
      else $error("run switch ignored");
   step_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      channel_one.step |-> $past(tick_r) ##1 !channel_one.step) // RULE11
      else $error("step not a pulse");
   no_toggle_ts_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(lg_cfg_r[0].c1 == C_TOGGLE && lg_cfg_r[0].s1 < 5'(N_TS))) // RULE17
      else $error("toggle on time signal");
   preset_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      tc_cfg_r[0].preset <= 13'(TC_MAX) &&
      tc_cnt_r[0] <= 13'(TC_MAX)) // RULE20
      else $error("timer preset over limit");
   pattern_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_pattern_select <= 5'd20) // RULE13
      else $error("pattern over limit");
endmodule

// file: tb/field_model.sv
// field contacts and time signals seen by the controller
`timescale 1ns/10ps
module field_model (
   input wire logic pclk,
   input wire logic [9:0] level,
   input wire logic [15:0] ts,
   output logic [9:0] contact_input = '0,
   output logic [15:0] time_signal_n = '0
);
   // levels move only on an edge; the bench keeps each for at least 2 ticks
   always @(posedge pclk) begin
      contact_input <= level;
      time_signal_n <= ts;
   end
endmodule

// file: tb/discrete_io_logic_unit_tb.sv
// self-checking bench of the discrete i/o logic unit
`timescale 1ns/10ps
module discrete_io_logic_unit_tb;
   import dio_pkg::*;
   localparam int TC = 50;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic opt = 1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, e, a, x;
   logic [9:0] lvl = '0, ci;
   logic [15:0] ts = '0, tsn;
   logic [8:0] do_drive, pol;
   logic [3:0] dir;
   logic [2:0] ev;
   logic [4:0] pat;
   ch_cmd_t c1, c2;
   logic_cfg_t cfg;
   int errors = 0, tests_run = 0, seed = 32'hc3c2ecdd;
   int t = 0, p;
   // ************************************************
   // clock, parts
   // ************************************************
   always #20 pclk = ~pclk;
   field_model i_field (.pclk(pclk), .level(lvl), .ts(ts),
      .contact_input(ci), .time_signal_n(tsn));
   discrete_io_logic_unit #(.TICK_CYCLES(TC)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .contact_input(ci),
      .option_fitted(opt), .time_signal_n(tsn), .process_value(16'sh0),
      .do_drive(do_drive), .event_output_n(ev), .channel_one(c1),
      .channel_two(c2), .start_pattern_select(pat));
   // ************************************************
   // tasks
   // ************************************************
   // one apb transfer; waits on pready, bounded by the watchdog
   task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic tk(input int n);
      repeat (n * TC) @(posedge pclk);
   endtask
   task final_report;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog well beyond the ~7900 cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      final_report;
   end
   // main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, OFS_ALARM, 0);
      chk("alarm_reset", r, RST_ALARM);
      apb(0, 12'h100, 0);
      chk("unmapped_err", 32'(e), 1);
      pol = 9'($random(seed));
      dir = 4'($random(seed));
      ts <= 16'($random(seed));
      apb(1, OFS_CTRL, 32'(pol));
      apb(1, OFS_ROUTE, 32'h0000_01ff);
      apb(1, OFS_DIRECT, 32'(dir));
      tk(3);
      chk("direct_out", 32'(do_drive[8:5]), 32'(dir ^ pol[8:5]));
      opt <= 0;
      tk(3);
      chk("option_off", 32'(do_drive[8:5]), 0);
      opt <= 1;
      apb(1, OFS_FUNC_LO, 32'h0000_0077);
      // every operator with source one passed and negated
      for (int op = 0; op < 3; op++) begin
         for (int c = 0; c < 2; c++) begin
            cfg = '{op: 2'(op), c2: 2'b00, c1: 2'(c), s2: 5'd17, s1: 5'd16};
            apb(1, OFS_LOGIC0, 32'(cfg));
            for (int v = 0; v < 4; v++) begin
               lvl <= 10'(v);
               tk(3);
               a = v[0] ^ c[0];
               x = op == 0 ? a & v[1] : op == 1 ? a | v[1] : a ^ v[1];
               chk("logic_ev", 32'(ev[0]), 32'(x));
            end
         end
      end
      // toggle on a time signal is stored as pass
      lvl <= '0;
      cfg = '{op: 2'(OP_AND), c2: 2'(C_PASS), c1: 2'(C_TOGGLE),
         s2: 5'd0, s1: 5'd5};
      apb(1, OFS_LOGIC0, 32'(cfg));
      apb(0, OFS_LOGIC0, 0);
      chk("toggle_refused", 32'(r[11:10]), 32'(C_PASS));
      // toggle on contact 1, source two unused (index past the end)
      cfg = '{op: 2'(OP_OR), c2: 2'(C_PASS), c1: 2'(C_TOGGLE),
         s2: 5'd31, s1: 5'd16};
      apb(1, OFS_LOGIC0, 32'(cfg));
      tk(2);
      for (int n = 0; n < 4; n++) begin
         lvl <= 10'(!n[0]);
         if (!n[0]) t = !t;
         tk(4); // latch flips one tick after the sampled edge
         chk("toggle_ev", 32'(ev[0]), 32'(t));
      end
      // five-bit start pattern on inputs 1-5, clamped at 20
      apb(1, OFS_FUNC_LO, 32'h000b_bbbb);
      for (int n = 0; n < 4; n++) begin
         p = $random(seed) & 31;
         lvl <= 10'(p);
         tk(3);
         chk("pattern", 32'(pat), 32'(p > 20 ? 20 : p));
      end
      // run switch, forced reset and manual on inputs 1, 2 and 4
      apb(1, OFS_FUNC_LO, 32'h0000_6021);
      for (int v = 0; v < 16; v++) begin
         lvl <= 10'(v);
         tk(3);
         chk("run", 32'(c1.run), 32'(v[0] & !v[1]));
         chk("hand", 32'(c1.hand), 32'(v[3]));
      end
      final_report;
   end
endmodule
